// ### inc/ssr_pkg.sv
// constants and types of the synchronous slave serial receiver
// ----------------------------------------------------------------------------
// Notes on behaviour
// (R1) slave reception works as master reception, continuous receive held on
// (R2) single-receive enable is ignored while configured as synchronous slave
// (R3) a character can be received asleep if continuous receive was set first
// (R4) a completed character moves from shift register to receive data
// (R5) receive interrupt enable lets the receive event wake the device
// (R6) with global enable also set, wake branches to the fixed vector address
// (R7) needs clocked mode, port on, continuous receive and clock source clear
// (R8) address detection is not offered; address-detect enable must stay clear
// (R9) receive flag sets on completion; request raised if enabled
// (R10) nine-bit mode shows top character's ninth bit in the status field
// (R11) clearing continuous receive clears a pending overrun error
// (R12) only synchronous slave mode keeps shifting during sleep
// (R13) shift registers are clocked by the link clock the master supplies
// (R14) receive flag clears only when every buffered character has been read
// (R15) asleep, data and clock pins are accepted and a full word wakes
// (R16) data line is sampled on the trailing link clock edge and shifted in
// (R17) master gives one link clock per data bit, no extra clocks
// (R18) two-character buffer; third sets overrun, keeps data, halts receive
// (R19) completion crosses into the system clock domain before buffer update
// (R20) clock pin output driver stays disabled in slave mode
// ----------------------------------------------------------------------------
package ssr_pkg;

    // register byte addresses
    localparam logic [7:0] ADR_RCV_STAT_CTL = 8'h00;
    localparam logic [7:0] ADR_XMT_STAT_CTL = 8'h04;
    localparam logic [7:0] ADR_RCV_DATA     = 8'h08;
    localparam logic [7:0] ADR_XMT_DATA     = 8'h0c;
    localparam logic [7:0] ADR_INT_ENA_ONE  = 8'h10;
    localparam logic [7:0] ADR_INT_FLG_ONE  = 8'h14;
    localparam logic [7:0] ADR_CORE_CTL     = 8'h18;

    // receive_status_control fields
    localparam int POS_PORT_EN    = 7;
    localparam int POS_NINE_SEL   = 6;
    localparam int POS_SINGLE_RX  = 5;
    localparam int POS_CONT_RX    = 4;
    localparam int POS_ADDR_DET   = 3;
    localparam int POS_FRAME_ERR  = 2;
    localparam int POS_OVERRUN    = 1;
    localparam int POS_NINE_BIT   = 0;
    // transmit_status_control fields
    localparam int POS_CLK_SRC    = 7;
    localparam int POS_CLOCKED    = 4;
    localparam int POS_SR_EMPTY   = 1;
    // interrupt_enable_one / interrupt_flags_one
    localparam int POS_RX_INT     = 5;
    // core control fields
    localparam int POS_GLOBAL_EN  = 7;
    localparam int POS_PERIPH_EN  = 6;
    localparam int POS_SLEEP      = 0;

    // reset values and transmit write mask
    localparam logic [7:0] RST_RCV_STAT_CTL = 8'h00;
    localparam logic [7:0] RST_XMT_STAT_CTL = 8'h02;
    localparam logic [7:0] RST_XMT_DATA     = 8'h00;
    localparam logic [7:0] RST_INT_ENA_ONE  = 8'h00;
    localparam logic [7:0] RST_CORE_CTL     = 8'h00;
    localparam logic [7:0] XMT_WR_MASK      = 8'hf5;

    localparam logic [12:0] ISR_VECTOR     = 13'h0004;
    localparam logic [3:0]  BITS_EIGHT     = 4'h8;
    localparam logic [3:0]  BITS_NINE      = 4'h9;
    localparam logic [1:0]  BUF_DEPTH      = 2'h2;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssr_wb_req_t;

    typedef enum logic [2:0] {
        RX_OFF   = 3'b001,
        RX_SHIFT = 3'b010,
        RX_HOLD  = 3'b100
    } ssr_rx_state_t;

endpackage : ssr_pkg

// ### core/ssr_receiver.sv
// synchronous slave serial receiver with wishbone register access
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ssr_receiver
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire ssr_pkg::ssr_wb_req_t wbReq,
    output logic                      wbAck_r,
    output logic [31:0]               wbDat_r,
    input  wire logic                 linkClkIn,
    input  wire logic                 linkDatIn,
    output logic                      linkClkOut_r,
    output logic                      linkClkOe_r,
    output logic                      linkDatOut_r,
    output logic                      linkDatOe_r,
    output logic                      intReq_r,
    output logic                      wakePulse_r,
    output logic                      branchPulse_r,
    output logic [12:0]               branchAddr_r
);
    import ssr_pkg::*;

    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic [1:0] rstSync_r;
    logic       rstN;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rstSync_r <= 2'b00;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstN);

    // ------------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------------
    logic [7:0]    rcvCtl_r;
    logic [7:0]    xmtCtl_r;
    logic [7:0]    xmtData_r;
    logic [7:0]    intEna_r;
    logic [7:0]    coreCtl_r;
    logic          overrun_r;
    logic [8:0]    rxBuf_r [0:1];
    logic          rdPtr_r;
    logic          wrPtr_r;
    logic [1:0]    count_r;
    logic [8:0]    shift_r;
    logic [3:0]    bitCnt_r;
    ssr_rx_state_t rxState_r;
    ssr_rx_state_t rxState_nxt;
    logic          wbTake;
    logic          wbWr;
    logic          popEv;
    logic          pushEv;
    logic          charDone_r;
    logic          slaveRx;
    logic          recvFlag;
    logic          wakeEv;
    logic [8:0]    topEntry;
    logic [7:0]    rcvView;
    logic [7:0]    readMux;

    // the access takes effect at the edge where the master sees ack
    assign wbTake = wbReq.cyc & wbReq.stb & wbAck_r;
    assign wbWr   = wbTake & wbReq.we & wbReq.sel[0];
    assign popEv  = wbTake & !wbReq.we & (wbReq.adr == ADR_RCV_DATA)
                    & (count_r != 2'h0);

    // clocked mode, port on, slave clock, continuous receive
    assign slaveRx = rcvCtl_r[POS_PORT_EN] & xmtCtl_r[POS_CLOCKED]  // [R7]
                     & !xmtCtl_r[POS_CLK_SRC] & rcvCtl_r[POS_CONT_RX]
                     & !rcvCtl_r[POS_ADDR_DET];                     // [R8]

    assign topEntry = rxBuf_r[rdPtr_r];
    assign recvFlag = (count_r != 2'h0);                            // [R14]
    assign rcvView  = {rcvCtl_r[7:3], 1'b0, overrun_r,
                       recvFlag ? topEntry[8] : 1'b0};              // [R10]

    always_comb
    begin
        readMux = 8'h00;
        case (wbReq.adr)
            ADR_RCV_STAT_CTL: readMux = rcvView;
            ADR_XMT_STAT_CTL: readMux = xmtCtl_r;
            ADR_RCV_DATA:     readMux = recvFlag ? topEntry[7:0] : 8'h00;
            ADR_INT_ENA_ONE:  readMux = intEna_r;
            ADR_INT_FLG_ONE:  readMux = 8'(recvFlag) << POS_RX_INT;       // [R9]
            ADR_CORE_CTL:     readMux = coreCtl_r;
            default:          readMux = 8'h00;
        endcase
    end

    // one wait cycle, ack for one cycle, unmapped reads give zero
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wbAck_r <= 1'b0;
            wbDat_r <= 32'h0000_0000;
        end
        else
        begin
            wbAck_r <= wbReq.cyc & wbReq.stb & !wbAck_r;
            wbDat_r <= {24'h00_0000, readMux};
        end
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rcvCtl_r  <= RST_RCV_STAT_CTL;
            xmtCtl_r  <= RST_XMT_STAT_CTL;
            xmtData_r <= RST_XMT_DATA;
            intEna_r  <= RST_INT_ENA_ONE;
        end
        else if (wbWr)
        begin
            case (wbReq.adr)
                ADR_RCV_STAT_CTL: rcvCtl_r <= {wbReq.dat[7:3], 3'b000};
                ADR_XMT_STAT_CTL:
                    xmtCtl_r <= (wbReq.dat[7:0] & XMT_WR_MASK)
                                | RST_XMT_STAT_CTL;
                ADR_XMT_DATA:     xmtData_r <= wbReq.dat[7:0];
                ADR_INT_ENA_ONE:  intEna_r  <= wbReq.dat[7:0];
                default:          intEna_r  <= intEna_r;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // sleep and wake
    // ------------------------------------------------------------------------
    assign wakeEv = coreCtl_r[POS_SLEEP] & recvFlag & intEna_r[POS_RX_INT];
    // wake clears sleep even if software writes sleep in the same cycle
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            coreCtl_r <= RST_CORE_CTL;
        else if (wakeEv)
            coreCtl_r[POS_SLEEP] <= 1'b0;                           // [R5]
        else if (wbWr && wbReq.adr == ADR_CORE_CTL)
            coreCtl_r <= wbReq.dat[7:0];
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            intReq_r      <= 1'b0;
            wakePulse_r   <= 1'b0;
            branchPulse_r <= 1'b0;
            branchAddr_r  <= ISR_VECTOR;
        end
        else
        begin
            intReq_r      <= recvFlag & intEna_r[POS_RX_INT];       // [R9]
            wakePulse_r   <= wakeEv;                            // [R5] [R15]
            branchPulse_r <= wakeEv & coreCtl_r[POS_GLOBAL_EN];     // [R6]
            branchAddr_r  <= ISR_VECTOR;
        end
    end

    // ------------------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------------------
    logic [1:0] ckSync_r;
    logic [1:0] dtSync_r;
    logic       ckPrev_r;
    logic       trailEdge;

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            ckSync_r <= 2'b00;
            dtSync_r <= 2'b00;
            ckPrev_r <= 1'b0;
        end
        else
        begin
            ckSync_r <= {ckSync_r[0], linkClkIn};
            dtSync_r <= {dtSync_r[0], linkDatIn};
            ckPrev_r <= ckSync_r[1];
        end
    end
    assign trailEdge = ckPrev_r & !ckSync_r[1];                     // [R16]

    // receive only: neither pin is ever driven in slave mode
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            linkClkOut_r <= 1'b0;
            linkClkOe_r  <= 1'b0;
            linkDatOut_r <= 1'b0;
            linkDatOe_r  <= 1'b0;
        end
        else
        begin
            linkClkOut_r <= 1'b0;
            linkClkOe_r  <= 1'b0;                                   // [R20]
            linkDatOut_r <= 1'b0;
            linkDatOe_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // receive state
    // ------------------------------------------------------------------------
    // the single-receive bit is not part of any term below
    always_comb
    begin
        case (rxState_r)
            RX_OFF:   rxState_nxt = slaveRx ? RX_SHIFT : RX_OFF;    // [R2]
            RX_SHIFT: rxState_nxt = !slaveRx ? RX_OFF
                                  : overrun_r ? RX_HOLD : RX_SHIFT; // [R1]
            RX_HOLD:  rxState_nxt = !slaveRx ? RX_OFF : RX_HOLD;    // [R18]
            default:  rxState_nxt = RX_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            rxState_r <= RX_OFF;
        else
            rxState_r <= rxState_nxt;
    end

    // shifting runs off sampled link edges, so it keeps going in sleep
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            shift_r    <= 9'h000;
            bitCnt_r   <= 4'h0;
            charDone_r <= 1'b0;
        end
        else if (rxState_r != RX_SHIFT || !slaveRx)
        begin
            bitCnt_r   <= 4'h0;                                     // [R12]
            charDone_r <= 1'b0;
        end
        else if (trailEdge)                                     // [R13] [R3]
        begin
            shift_r <= {dtSync_r[1], shift_r[8:1]};                 // [R16]
            if (bitCnt_r == (rcvCtl_r[POS_NINE_SEL] ? BITS_NINE - 4'h1
                                                    : BITS_EIGHT - 4'h1))
            begin
                bitCnt_r   <= 4'h0;                                 // [R17]
                charDone_r <= 1'b1;
            end
            else
            begin
                bitCnt_r   <= bitCnt_r + 4'h1;
                charDone_r <= 1'b0;
            end
        end
        else
            charDone_r <= 1'b0;
    end

    // ------------------------------------------------------------------------
    // two-character buffer and overrun
    // ------------------------------------------------------------------------
    // completion comes from the already synchronised edge stream
    assign pushEv = charDone_r & !overrun_r                          // [R19]
                    & ((count_r != BUF_DEPTH) | popEv);

    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdPtr_r <= 1'b0;
            wrPtr_r <= 1'b0;
            count_r <= 2'h0;
        end
        else if (!rcvCtl_r[POS_PORT_EN])
        begin
            rdPtr_r <= 1'b0;
            wrPtr_r <= 1'b0;
            count_r <= 2'h0;
        end
        else
        begin
            if (pushEv)
            begin
                rxBuf_r[wrPtr_r] <= rcvCtl_r[POS_NINE_SEL] ? shift_r
                                    : {1'b0, shift_r[8:1]};         // [R4]
                wrPtr_r <= !wrPtr_r;
            end
            if (popEv)
                rdPtr_r <= !rdPtr_r;
            count_r <= count_r + 2'(pushEv) - 2'(popEv);            // [R14]
        end
    end

    // overrun set wins; cleared only by dropping continuous receive or the port enable
    always_ff @(posedge ref_clk or negedge rstN)
    begin
        if (!rstN)
            overrun_r <= 1'b0;
        else if (charDone_r && count_r == BUF_DEPTH && !popEv)
            overrun_r <= 1'b1;                                      // [R18]
        else if (!rcvCtl_r[POS_CONT_RX] || !rcvCtl_r[POS_PORT_EN])
            overrun_r <= 1'b0;                                      // [R11]
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    bus_ack_pulse_a: assert property (wbAck_r |=> !wbAck_r)
        else $error("ack held longer than one cycle");

    flag_tracks_buffer_a: assert property (                         // [R14]
        (count_r == 2'h0) |=> !intReq_r)
        else $error("receive flag out of step with buffer");

    overrun_blocks_a: assert property (                             // [R18]
        (overrun_r && !popEv && rcvCtl_r[POS_PORT_EN])
        |=> count_r == $past(count_r))
        else $error("buffer changed during overrun");

    overrun_clear_a: assert property (                              // [R11]
        (!rcvCtl_r[POS_CONT_RX] && !(charDone_r && count_r == BUF_DEPTH))
        |=> !overrun_r)
        else $error("overrun survived continuous receive clear");

    clock_pin_off_a: assert property (                              // [R20]
        slaveRx |-> ##1 !linkClkOe_r ##1 !linkClkOe_r)
        else $error("clock pin driven in slave mode");

    sleep_wake_a: assert property (                                 // [R5]
        wakeEv |=> wakePulse_r && !coreCtl_r[POS_SLEEP])
        else $error("receive event did not wake");

    vector_branch_a: assert property (                              // [R6]
        wakeEv |=> branchPulse_r == $past(coreCtl_r[POS_GLOBAL_EN])
                   && branchAddr_r == ISR_VECTOR)
        else $error("branch does not follow global enable");

    int_request_a: assert property (                                // [R9]
        (recvFlag && intEna_r[POS_RX_INT]) |=> intReq_r)
        else $error("interrupt request missing");

    ninth_bit_a: assert property (                                  // [R10]
        recvFlag |-> rcvView[POS_NINE_BIT] == topEntry[8])
        else $error("ninth bit not from top character");

    rx_disabled_a: assert property (                                // [R7]
        !slaveRx |=> bitCnt_r == 4'h0 && !charDone_r)
        else $error("shifting while not in slave reception");

    push_done_a: assert property (                                  // [R4]
        (charDone_r && count_r == 2'h0 && !overrun_r
         && rcvCtl_r[POS_PORT_EN]) |=> count_r == 2'h1)
        else $error("completed character not buffered");

endmodule : ssr_receiver
`default_nettype wire

// ### tb/ssr_link_master.sv
// behavioural external master that clocks characters into the receiver
`timescale 1ns/100ps
`default_nettype none
module ssr_link_master
(
    output var logic linkClk,
    output var logic linkDat
);
    // ------------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------------
    initial
    begin
        linkClk = 1'b0;
        linkDat = 1'b1;
    end

    // clock stands low between frames; data moves only while clock is low
    task automatic send(input logic [8:0] d, input logic nine,
                        input int gapNs);
        int nb;
        nb = nine ? 9 : 8;
        for (int i = 0; i < nb; i++)
        begin
            linkDat = d[i];
            #20;
            linkClk = 1'b1;
            #40;
            linkClk = 1'b0;
            #20;
        end
        // released line: show the inverse so a stale sample is caught
        linkDat = ~d[nb-1];
        #(gapNs);
    endtask : send
endmodule : ssr_link_master
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the synchronous slave serial receiver
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ssr_pkg::*;
    typedef struct { logic [31:0] v; string nm; } ssr_exp_t;
    localparam logic [7:0] RADR [7] = '{ADR_RCV_STAT_CTL, ADR_XMT_STAT_CTL,
        ADR_RCV_DATA, ADR_INT_ENA_ONE, ADR_INT_FLG_ONE, ADR_CORE_CTL, 8'h1c};
    localparam logic [7:0] BADX [5] = '{8'h90, 8'h00, 8'h10, 8'h10, 8'h10};
    localparam logic [7:0] BADR [5] = '{8'h90, 8'h90, 8'ha0, 8'h98, 8'h10};

    logic        ref_clk = 1'b0;
    logic        nrst;
    ssr_wb_req_t wbReq;
    logic        wbAck_r;
    logic [31:0] wbDat_r;
    logic        linkClk;
    logic        linkDat;
    logic        linkClkOut_r;
    logic        linkDatOut_r;
    logic        linkClkOe_r;
    logic        linkDatOe_r;
    logic        intReq_r;
    logic        wakePulse_r;
    logic        branchPulse_r;
    logic [12:0] branchAddr_r;
    int          n_fail = 0;
    int          compares = 0;
    int          nWake = 0;
    int          nBranch = 0;
    int          w0;
    int          b0;
    logic [7:0]  rnd;
    logic [7:0]  bt [3];
    logic [8:0]  d9;
    ssr_exp_t    expQ [$];
    ssr_exp_t    cur;

    always #2.5 ref_clk = ~ref_clk;

    ssr_receiver ssr_receiver_inst
    (
        .ref_clk       (ref_clk),
        .nrst          (nrst),
        .wbReq         (wbReq),
        .wbAck_r       (wbAck_r),
        .wbDat_r       (wbDat_r),
        .linkClkIn     (linkClk),
        .linkDatIn     (linkDat),
        .linkClkOut_r  (linkClkOut_r),
        .linkClkOe_r   (linkClkOe_r),
        .linkDatOut_r  (linkDatOut_r),
        .linkDatOe_r   (linkDatOe_r),
        .intReq_r      (intReq_r),
        .wakePulse_r   (wakePulse_r),
        .branchPulse_r (branchPulse_r),
        .branchAddr_r  (branchAddr_r)
    );

    ssr_link_master ssr_link_master_inst
    (
        .linkClk (linkClk),
        .linkDat (linkDat)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    function automatic void check(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endfunction : check

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                   dat: {24'h0, d}};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wbAck_r !== 1'b1 && n < 50);
        if (n >= 50)
            n_fail++;
        wbReq <= '0;
        @(posedge ref_clk);
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [7:0] e, string nm);
        expQ.push_back('{{24'h0, e}, nm});
        wb(1'b0, adr, 8'h00);
    endtask : rd

    task automatic frame(input logic [8:0] d, input logic nine, input int g);
        ssr_link_master_inst.send(d, nine, g);
        repeat (8) @(posedge ref_clk);
    endtask : frame

    // ------------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (wakePulse_r === 1'b1)
            nWake++;
        if (branchPulse_r === 1'b1)
            nBranch++;
        if (wbAck_r === 1'b1 && wbReq.we === 1'b0 && expQ.size() > 0)
        begin
            cur = expQ.pop_front();
            check(cur.nm, cur.v, wbDat_r);
        end
    end

    initial
    begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        wbReq = '0;
        nrst = 1'b0;
        rnd = 8'h2a;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wb(1'b1, 8'h1c, 8'hff);
        for (int i = 0; i < 7; i++)
            rd(RADR[i], (i == 1) ? 8'h02 : 8'h00, "reset value");
        wb(1'b1, ADR_XMT_STAT_CTL, 8'h10);
        wb(1'b1, ADR_RCV_STAT_CTL, 8'h90);
        rd(ADR_XMT_STAT_CTL, 8'h12, "transmit status");
        rnd = lfsr_next(rnd);
        frame({1'b0, rnd}, 1'b0, 400);
        rd(ADR_INT_FLG_ONE, 8'h20, "receive flag");
        rd(ADR_RCV_DATA, rnd, "receive data");
        rd(ADR_INT_FLG_ONE, 8'h00, "flag after read");
        // three characters back to back with no read between
        for (int i = 0; i < 3; i++)
        begin
            rnd = lfsr_next(rnd);
            bt[i] = rnd;
            frame({1'b0, rnd}, 1'b0, 0);
        end
        rd(ADR_RCV_STAT_CTL, 8'h92, "overrun status");
        rd(ADR_RCV_DATA, bt[0], "first kept");
        rd(ADR_INT_FLG_ONE, 8'h20, "flag one left");
        rd(ADR_RCV_DATA, bt[1], "second kept");
        rd(ADR_INT_FLG_ONE, 8'h00, "flag emptied");
        frame({1'b0, lfsr_next(rnd)}, 1'b0, 400);
        rd(ADR_INT_FLG_ONE, 8'h00, "blocked flag");
        wb(1'b1, ADR_RCV_STAT_CTL, 8'h80);
        rd(ADR_RCV_STAT_CTL, 8'h80, "overrun cleared");
        // nine-bit character with single receive also set
        wb(1'b1, ADR_RCV_STAT_CTL, 8'hf0);
        rnd = lfsr_next(rnd);
        d9 = {rnd[0], lfsr_next(rnd)};
        frame(d9, 1'b1, 400);
        rd(ADR_RCV_STAT_CTL, {7'h78, d9[8]}, "ninth bit");
        rd(ADR_RCV_DATA, d9[7:0], "nine-bit low");
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b1, ADR_XMT_STAT_CTL, BADX[i]);
            wb(1'b1, ADR_RCV_STAT_CTL, BADR[i]);
            rnd = lfsr_next(rnd);
            frame({1'b0, rnd}, 1'b0, 400);
            rd(ADR_INT_FLG_ONE, 8'h00, "refused flag");
        end
        wb(1'b1, ADR_XMT_STAT_CTL, 8'h10);
        wb(1'b1, ADR_RCV_STAT_CTL, 8'h90);
        wb(1'b1, ADR_INT_ENA_ONE, 8'h20);
        // sleep with and without the global enable
        for (int g = 1; g >= 0; g--)
        begin
            wb(1'b1, ADR_CORE_CTL, {g[0], 7'h01});
            w0 = nWake;
            b0 = nBranch;
            rnd = lfsr_next(rnd);
            frame({1'b0, rnd}, 1'b0, 400);
            repeat (4) @(posedge ref_clk);
            check("wake count", 1, nWake - w0);
            check("branch count", g, nBranch - b0);
            check("branch address", ISR_VECTOR, branchAddr_r);
            check("interrupt request", 1, intReq_r);
            rd(ADR_CORE_CTL, {g[0], 7'h00}, "core control");
            rd(ADR_RCV_DATA, rnd, "sleep data");
            repeat (3) @(posedge ref_clk);
            check("request after read", 0, intReq_r);
        end
        check("clock pin enable", 0, linkClkOe_r);
        check("data pin enable", 0, linkDatOe_r);
        check("clock pin out", 0, linkClkOut_r);
        check("data pin out", 0, linkDatOut_r);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
